//--- rtl/fpu_arith_store_decoder.v
// decoder and sequencer for the multiply, transcendental, store and subtract slice
`timescale 1ns/1ps
`default_nettype none
`include "fpu_dec_defines.vh"
// Function
// - register multiply forms, DC and D8
// - memory multiply, double or single real
// - multiply into element n, then pop
// - integer multiply, 32 or 16 bit
// - partial arctangent into element 1, pop
// - both remainder forms, 82 to 91
// - tangent of top, then push one
// - round top to integer
// - restore unit state from memory
// - save unit state, wait form adds idle
// - scale top by power of two
// - sine and combined sine cosine
// - square root of top
// - store top without pop, 2 clocks
// - store top then pop, 2 clocks
// - packed BCD store then pop
// - integer store without pop
// - integer store then pop
// - control word and environment store timing
// - status word into accumulator
// - subtract forms, 4 to 7 clocks
// - subtract into element n, then pop
// - wait stalls issue until unit idle
module fpu_arith_store_decoder #(
	parameter CW = 8
) (
	input wire mclk,
	input wire rst_n,
	input wire issue_valid,
	input wire [7:0] issue_escape,
	input wire [7:0] issue_modrm,
	input wire issue_wait_prefix,
	input wire unit_busy,
	input wire [15:0] status_word,
	output reg issue_ready,
	output reg op_start,
	output reg [4:0] op_code,
	output reg [2:0] op_mem_format,
	output reg op_uses_element,
	output reg op_to_element,
	output reg [2:0] op_element,
	output reg [2:0] op_top,
	output reg op_pop,
	output reg op_push,
	output reg [CW-1:0] op_clocks,
	output reg op_done,
	output reg op_illegal,
	output reg acc_load,
	output reg [15:0] acc_data,
	output reg [2:0] top_ptr,
	output reg seq_busy
);
	// ****************************************
	// decode table
	// ****************************************
	// packed entry: legal, code, format, to_elem, uses_elem, offset, pop, push, clocks
	function [23:0] entry;
		input [4:0] code;
		input [2:0] fmt;
		input to_elem;
		input uses_elem;
		input [2:0] off;
		input pop;
		input push;
		input [7:0] clk;
		begin
			entry = {1'b1, code, fmt, to_elem, uses_elem, off, pop, push, clk};
		end
	endfunction
	function [23:0] decode;
		input [7:0] esc;
		input [7:0] modrm;
		reg reg_form;
		reg [2:0] rf;
		reg [2:0] n;
		reg [4:0] hi5;
		begin
			reg_form = (modrm[`MODRM_MOD_HI:`MODRM_MOD_LO] == `MODRM_MOD_REG);
			rf = modrm[`MODRM_REG_HI:`MODRM_REG_LO];
			n = modrm[`MODRM_N_HI:`MODRM_N_LO];
			hi5 = modrm[7:3];
			decode = 24'h000000;
			if (esc == `OP_WAIT_BYTE) begin
				decode = entry(`OPC_WAIT, `FMT_NONE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, `CLK_WAIT);
			end else if (esc == `ESC_D8) begin
				if (reg_form && hi5 == 5'h19) begin
					decode = entry(`OPC_MUL, `FMT_NONE, 1'b0, 1'b1, n, 1'b0, 1'b0, `CLK_MUL);
				end else if (reg_form && hi5 == 5'h1C) begin
					decode = entry(`OPC_SUB, `FMT_NONE, 1'b0, 1'b1, n, 1'b0, 1'b0, `CLK_SUB);
				end else if (!reg_form && rf == 3'h1) begin
					decode = entry(`OPC_MUL, `FMT_SINGLE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
						`CLK_MUL_SINGLE);
				end else if (!reg_form && rf == 3'h4) begin
					decode = entry(`OPC_SUB, `FMT_SINGLE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, `CLK_SUB);
				end
			end else if (esc == `ESC_D9) begin
				if (reg_form) begin
					case (modrm)
						8'hD0: decode = entry(`OPC_NOP, `FMT_NONE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, `CLK_NOP);
						8'hF3: decode = entry(`OPC_PATAN, `FMT_NONE, 1'b1, 1'b1, 3'h1, 1'b1, 1'b0,
							`CLK_PATAN);
						8'hF8: decode = entry(`OPC_PREM, `FMT_NONE, 1'b0, 1'b1, 3'h1, 1'b0, 1'b0,
							`CLK_PREM);
						8'hF5: decode = entry(`OPC_PREM1, `FMT_NONE, 1'b0, 1'b1, 3'h1, 1'b0, 1'b0,
							`CLK_PREM);
						8'hF2: decode = entry(`OPC_PTAN, `FMT_NONE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b1,
							`CLK_PTAN);
						8'hFC: decode = entry(`OPC_RND, `FMT_NONE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
							`CLK_RND);
						8'hFD: decode = entry(`OPC_SCALE, `FMT_NONE, 1'b0, 1'b1, 3'h1, 1'b0, 1'b0,
							`CLK_SCALE);
						8'hFE: decode = entry(`OPC_SIN, `FMT_NONE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
							`CLK_SIN);
						8'hFB: decode = entry(`OPC_SINCOS, `FMT_NONE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b1,
							`CLK_SINCOS);
						8'hFA: decode = entry(`OPC_SQRT, `FMT_NONE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
							`CLK_SQRT);
						default: decode = 24'h000000;
					endcase
				end else if (rf == 3'h2) begin
					decode = entry(`OPC_STORE, `FMT_SINGLE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
						`CLK_STORE);
				end else if (rf == 3'h3) begin
					decode = entry(`OPC_STORE, `FMT_SINGLE, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0,
						`CLK_STORE);
				end else if (rf == 3'h7) begin
					decode = entry(`OPC_STCW, `FMT_NONE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
						`CLK_STCW);
				end else if (rf == 3'h6) begin
					decode = entry(`OPC_STENV, `FMT_NONE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
						`CLK_STENV);
				end
			end else if (esc == `ESC_DA) begin
				if (!reg_form && rf == 3'h1) begin
					decode = entry(`OPC_IMUL, `FMT_INT32, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
						`CLK_IMUL32);
				end
			end else if (esc == `ESC_DB) begin
				if (reg_form && hi5 == 5'h1B) begin
					decode = entry(`OPC_STORE, `FMT_NONE, 1'b1, 1'b1, n, 1'b1, 1'b0,
						`CLK_STORE);
				end else if (!reg_form && rf == 3'h7) begin
					decode = entry(`OPC_STORE, `FMT_EXT, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0,
						`CLK_STORE);
				end else if (!reg_form && rf == 3'h2) begin
					decode = entry(`OPC_ISTORE, `FMT_INT32, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
						`CLK_IST32);
				end else if (!reg_form && rf == 3'h3) begin
					decode = entry(`OPC_ISTORE, `FMT_INT32, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0,
						`CLK_IST32);
				end
			end else if (esc == `ESC_DC) begin
				if (reg_form && hi5 == 5'h19) begin
					decode = entry(`OPC_MUL, `FMT_NONE, 1'b1, 1'b1, n, 1'b0, 1'b0, `CLK_MUL);
				end else if (reg_form && hi5 == 5'h1D) begin
					decode = entry(`OPC_SUB, `FMT_NONE, 1'b1, 1'b1, n, 1'b0, 1'b0, `CLK_SUB);
				end else if (!reg_form && rf == 3'h1) begin
					decode = entry(`OPC_MUL, `FMT_DOUBLE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, `CLK_MUL);
				end else if (!reg_form && rf == 3'h4) begin
					decode = entry(`OPC_SUB, `FMT_DOUBLE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, `CLK_SUB);
				end
			end else if (esc == `ESC_DD) begin
				if (reg_form && hi5 == 5'h1A) begin
					decode = entry(`OPC_STORE, `FMT_NONE, 1'b1, 1'b1, n, 1'b0, 1'b0,
						`CLK_STORE);
				end else if (!reg_form && rf == 3'h4) begin
					decode = entry(`OPC_RESTORE, `FMT_NONE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
						`CLK_RESTORE);
				end else if (!reg_form && rf == 3'h6) begin
					decode = entry(`OPC_SAVE, `FMT_NONE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
						`CLK_SAVE);
				end else if (!reg_form && rf == 3'h2) begin
					decode = entry(`OPC_STORE, `FMT_DOUBLE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
						`CLK_STORE);
				end else if (!reg_form && rf == 3'h3) begin
					decode = entry(`OPC_STORE, `FMT_DOUBLE, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0,
						`CLK_STORE);
				end
			end else if (esc == `ESC_DE) begin
				if (reg_form && hi5 == 5'h19) begin
					decode = entry(`OPC_MUL, `FMT_NONE, 1'b1, 1'b1, n, 1'b1, 1'b0, `CLK_MUL);
				end else if (reg_form && hi5 == 5'h1D) begin
					decode = entry(`OPC_SUB, `FMT_NONE, 1'b1, 1'b1, n, 1'b1, 1'b0, `CLK_SUB);
				end else if (!reg_form && rf == 3'h1) begin
					decode = entry(`OPC_IMUL, `FMT_INT16, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
						`CLK_IMUL16);
				end
			end else if (esc == `ESC_DF) begin
				if (modrm == `MODRM_STSW_AX) begin
					decode = entry(`OPC_STSW_AX, `FMT_NONE, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
						`CLK_STSW);
				end else if (!reg_form && rf == 3'h6) begin
					decode = entry(`OPC_BSTORE, `FMT_BCD, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0,
						`CLK_BSTORE);
				end else if (!reg_form && rf == 3'h2) begin
					decode = entry(`OPC_ISTORE, `FMT_INT16, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0,
						`CLK_IST16);
				end else if (!reg_form && rf == 3'h7) begin
					decode = entry(`OPC_ISTORE, `FMT_INT64, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0,
						`CLK_IST64);
				end else if (!reg_form && rf == 3'h3) begin
					decode = entry(`OPC_ISTORE, `FMT_INT16, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0,
						`CLK_IST16);
				end
			end
		end
	endfunction
	// ****************************************
	// sequencer
	// ****************************************
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_HOLD = 4'h2;
	localparam [3:0] ST_EXEC = 4'h4;
	localparam [3:0] ST_LOAD = 4'h8;

	reg [3:0] state;
	reg [23:0] held;
	reg held_wait;
	wire [23:0] dec;
	wire [2:0] top_now;
	wire timer_done;
	reg timer_load;
	reg [CW-1:0] timer_count;
	reg ptr_pop;
	reg ptr_push;
	wire [CW-1:0] held_clocks;
	assign dec = decode(issue_escape, issue_modrm);
	// the wait prefix costs the two clocks of a standalone wait on top of the body
	assign held_clocks = held[CW-1:0] + (held_wait ? `CLK_WAIT : {CW{1'b0}});
	fpu_cycle_timer #(.W(CW)) timer (
		.mclk(mclk), .rst_n(rst_n), .load(timer_load), .count(timer_count), .done(timer_done)
	);
	fpu_stack_ptr stack (
		.mclk(mclk), .rst_n(rst_n), .pop(ptr_pop), .push(ptr_push), .top(top_now)
	);

	always @(posedge mclk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			held <= 24'h000000;
			held_wait <= 1'b0;
			issue_ready <= 1'b1;
			op_start <= 1'b0;
			op_code <= `OPC_NOP;
			op_mem_format <= `FMT_NONE;
			op_uses_element <= 1'b0;
			op_to_element <= 1'b0;
			op_element <= 3'h0;
			op_top <= 3'h0;
			op_pop <= 1'b0;
			op_push <= 1'b0;
			op_clocks <= {CW{1'b0}};
			op_done <= 1'b0;
			op_illegal <= 1'b0;
			acc_load <= 1'b0;
			acc_data <= 16'h0000;
			top_ptr <= 3'h0;
			seq_busy <= 1'b0;
			timer_load <= 1'b0;
			timer_count <= {CW{1'b0}};
			ptr_pop <= 1'b0;
			ptr_push <= 1'b0;
		end else begin
			op_start <= 1'b0;
			op_done <= 1'b0;
			op_illegal <= 1'b0;
			acc_load <= 1'b0;
			timer_load <= 1'b0;
			ptr_pop <= 1'b0;
			ptr_push <= 1'b0;
			top_ptr <= top_now;
			case (state)
				ST_IDLE: begin
					if (issue_valid) begin
						if (!dec[23]) begin
							op_illegal <= 1'b1;
						end else begin
							held <= dec;
							held_wait <= issue_wait_prefix;
							issue_ready <= 1'b0;
							seq_busy <= 1'b1;
							state <= ST_HOLD;
						end
					end
				end
				ST_HOLD: begin
					// issue stays stalled while the arithmetic units are still busy
					if (!unit_busy) begin
						timer_load <= 1'b1;
						timer_count <= held_clocks;
						op_start <= 1'b1;
						op_code <= held[22:18];
						op_mem_format <= held[17:15];
						op_to_element <= held[14];
						op_uses_element <= held[13];
						op_element <= top_now + held[12:10];
						op_top <= top_now;
						op_pop <= held[9];
						op_push <= held[8];
						op_clocks <= held_clocks;
						state <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					if (timer_done) begin
						state <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					op_done <= 1'b1;
					ptr_pop <= held[9];
					ptr_push <= held[8];
					if (held[22:18] == `OPC_STSW_AX) begin
						acc_load <= 1'b1;
						acc_data <= status_word;
					end
					issue_ready <= 1'b1;
					seq_busy <= 1'b0;
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
					issue_ready <= 1'b1;
					seq_busy <= 1'b0;
				end
			endcase
		end
	end
endmodule // fpu_arith_store_decoder
`default_nettype wire

//--- shared/fpu_dec_defines.vh
// constants for the floating-point decode and sequencing slice
`ifndef FPU_DEC_DEFINES_VH
`define FPU_DEC_DEFINES_VH

// ****************************************
// escape bytes and special opcodes
// ****************************************
`define ESC_D8 8'hD8
`define ESC_D9 8'hD9
`define ESC_DA 8'hDA
`define ESC_DB 8'hDB
`define ESC_DC 8'hDC
`define ESC_DD 8'hDD
`define ESC_DE 8'hDE
`define ESC_DF 8'hDF
`define OP_WAIT_BYTE 8'h9B
`define MODRM_STSW_AX 8'hE0

// ****************************************
// modrm field positions
// ****************************************
`define MODRM_MOD_HI 7
`define MODRM_MOD_LO 6
`define MODRM_REG_HI 5
`define MODRM_REG_LO 3
`define MODRM_N_HI 2
`define MODRM_N_LO 0
`define MODRM_MOD_REG 2'h3

// ****************************************
// operation codes
// ****************************************
`define OPC_NOP 5'h00
`define OPC_MUL 5'h01
`define OPC_IMUL 5'h02
`define OPC_SUB 5'h03
`define OPC_PATAN 5'h04
`define OPC_PREM 5'h05
`define OPC_PREM1 5'h06
`define OPC_PTAN 5'h07
`define OPC_RND 5'h08
`define OPC_SCALE 5'h09
`define OPC_SIN 5'h0A
`define OPC_SINCOS 5'h0B
`define OPC_SQRT 5'h0C
`define OPC_STORE 5'h0D
`define OPC_ISTORE 5'h0E
`define OPC_BSTORE 5'h0F
`define OPC_RESTORE 5'h10
`define OPC_SAVE 5'h11
`define OPC_STCW 5'h12
`define OPC_STENV 5'h13
`define OPC_STSW_AX 5'h14
`define OPC_WAIT 5'h15

// ****************************************
// memory operand formats
// ****************************************
`define FMT_NONE 3'h0
`define FMT_SINGLE 3'h1
`define FMT_DOUBLE 3'h2
`define FMT_EXT 3'h3
`define FMT_INT32 3'h4
`define FMT_INT16 3'h5
`define FMT_INT64 3'h6
`define FMT_BCD 3'h7

// ****************************************
// clock counts, worst case of each range
// ****************************************
`define CLK_MUL 8'h06
`define CLK_MUL_SINGLE 8'h05
`define CLK_IMUL32 8'h0B
`define CLK_IMUL16 8'h0A
`define CLK_PATAN 8'hA1
`define CLK_PREM 8'h5B
`define CLK_PTAN 8'h81
`define CLK_RND 8'h14
`define CLK_RESTORE 8'h48
`define CLK_SAVE 8'h41
`define CLK_SCALE 8'h0E
`define CLK_SIN 8'h8C
`define CLK_SINCOS 8'hA1
`define CLK_SQRT 8'h3C
`define CLK_STORE 8'h02
`define CLK_BSTORE 8'h3F
`define CLK_IST32 8'h0D
`define CLK_IST16 8'h0A
`define CLK_IST64 8'h0D
`define CLK_STCW 8'h03
`define CLK_STENV 8'h16
`define CLK_STSW 8'h02
`define CLK_SUB 8'h07
`define CLK_NOP 8'h02
`define CLK_WAIT 8'h02

`endif

//--- rtl/fpu_cycle_timer.v
// down counter that times one operation and pulses when it ends
`timescale 1ns/1ps
`default_nettype none
module fpu_cycle_timer #(
	parameter W = 8
) (
	input wire mclk,
	input wire rst_n,
	input wire load,
	input wire [W-1:0] count,
	output reg done
);
	reg [W-1:0] remain;
	always @(posedge mclk) begin
		if (!rst_n) begin
			remain <= {W{1'b0}};
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				remain <= count;
			end else if (remain != {W{1'b0}}) begin
				remain <= remain - {{(W-1){1'b0}}, 1'b1};
				// pulse in the last counted cycle
				if (remain == {{(W-1){1'b0}}, 1'b1}) begin
					done <= 1'b1;
				end
			end
		end
	end
endmodule // fpu_cycle_timer
`default_nettype wire

//--- rtl/fpu_stack_ptr.v
// three-bit top-of-stack pointer of the register stack
`timescale 1ns/1ps
`default_nettype none
module fpu_stack_ptr (
	input wire mclk,
	input wire rst_n,
	input wire pop,
	input wire push,
	output reg [2:0] top
);
	// a pop moves the top up, a push moves it down; both together cancel
	always @(posedge mclk) begin
		if (!rst_n) begin
			top <= 3'h0;
		end else if (pop && !push) begin
			top <= top + 3'h1;
		end else if (push && !pop) begin
			top <= top - 3'h1;
		end
	end
endmodule // fpu_stack_ptr
`default_nettype wire

//--- testbench/fpu_arith_store_decoder_checker.sv
// concurrent checks on the decode and sequencing ports
`timescale 1ns/1ps
`default_nettype none
`include "fpu_dec_defines.vh"
module fpu_arith_store_decoder_checker #(
	parameter CW = 8
) (
	input wire mclk,
	input wire rst_n,
	input wire issue_valid,
	input wire issue_ready,
	input wire unit_busy,
	input wire op_start,
	input wire [4:0] op_code,
	input wire op_uses_element,
	input wire [2:0] op_element,
	input wire [2:0] op_top,
	input wire op_pop,
	input wire op_push,
	input wire [CW-1:0] op_clocks,
	input wire op_done,
	input wire op_illegal,
	input wire acc_load,
	input wire [2:0] top_ptr,
	input wire seq_busy
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ****
	// cycles since the last start, wide enough for the longest op
	// ****
	reg [CW+1:0] since_start;
	always @(posedge mclk) begin
		if (!rst_n || op_start) since_start <= {{(CW+1){1'b0}}, !rst_n ? 1'b0 : 1'b1};
		else since_start <= since_start + 1'b1;
	end
	sequence s_take;
		issue_valid && issue_ready;
	endsequence
	sequence s_take_clear;
		s_take ##1 (seq_busy && !unit_busy);
	endsequence
	a_take_goes_busy: assert property (s_take |=> (op_illegal || (!issue_ready && seq_busy)))
		else $error("take did not enter the busy state");
	a_start_after_take: assert property (s_take_clear |=> op_start)
		else $error("start missing two cycles after a take");
	a_start_not_busy: assert property (op_start |-> !$past(unit_busy))
		else $error("start while the unit was busy");
	// timer load, count, state change and done register add three cycles to the count
	a_done_count: assert property (op_done |-> since_start == {2'h0, op_clocks} + 2'h3)
		else $error("done not three cycles past the op clock count");
	a_ready_at_done: assert property (op_done |-> issue_ready && !seq_busy)
		else $error("sequencer not idle at done");
	a_pop_moves_top: assert property (op_done && op_pop && !op_push |-> ##2 top_ptr == $past(op_top, 2) + 3'h1)
		else $error("pop did not advance the top pointer");
	a_push_moves_top: assert property (op_done && op_push && !op_pop |-> ##2 top_ptr == $past(op_top, 2) - 3'h1)
		else $error("push did not retreat the top pointer");
	a_fixed_offset: assert property (op_start && (op_code == `OPC_PATAN || op_code == `OPC_PREM
		|| op_code == `OPC_PREM1 || op_code == `OPC_SCALE) |-> op_uses_element && op_element == op_top + 3'h1)
		else $error("element one not selected");
	a_store_clocks: assert property (op_start && op_code == `OPC_STORE |-> op_clocks == 8'h02 || op_clocks == 8'h04)
		else $error("store clock count wrong");
	a_sub_clocks: assert property (op_start && op_code == `OPC_SUB |-> op_clocks == 8'h07 || op_clocks == 8'h09)
		else $error("subtract clock count wrong");
	a_illegal_quiet: assert property (op_illegal |-> !seq_busy && !op_start && $past(issue_valid && issue_ready))
		else $error("illegal pulse without a dropped take");
	a_acc_with_status: assert property (acc_load |-> op_done && op_code == `OPC_STSW_AX)
		else $error("accumulator load outside status word op");
endmodule // fpu_arith_store_decoder_checker
bind fpu_arith_store_decoder fpu_arith_store_decoder_checker #(.CW(CW)) checker_i (
	.mclk(mclk), .rst_n(rst_n), .issue_valid(issue_valid), .issue_ready(issue_ready),
	.unit_busy(unit_busy), .op_start(op_start), .op_code(op_code),
	.op_uses_element(op_uses_element), .op_element(op_element), .op_top(op_top),
	.op_pop(op_pop), .op_push(op_push), .op_clocks(op_clocks), .op_done(op_done),
	.op_illegal(op_illegal), .acc_load(acc_load), .top_ptr(top_ptr), .seq_busy(seq_busy)
);
`default_nettype wire

//--- testbench/fpu_issue_model.sv
// issuing pipeline model: offers instructions, drives unit busy and status word
`timescale 1ns/1ps
`default_nettype none
module fpu_issue_model (
	input wire logic mclk,
	input wire logic issue_ready,
	output logic issue_valid,
	output logic [7:0] issue_escape,
	output logic [7:0] issue_modrm,
	output logic issue_wait_prefix,
	output logic unit_busy,
	output logic [15:0] status_word
);
	initial begin
		issue_valid = 1'b0;
		issue_escape = 8'h00;
		issue_modrm = 8'h00;
		issue_wait_prefix = 1'b0;
		unit_busy = 1'b0;
		status_word = 16'h0000;
	end
	// ****
	// one offer, held until taken; released lines show the inverse
	// ****
	task automatic issue(input logic [7:0] esc, input logic [7:0] modrm, input logic pfx,
		input int stall, output logic ok);
		ok = 1'b0;
		@(negedge mclk);
		issue_valid = 1'b1;
		issue_escape = esc;
		issue_modrm = modrm;
		issue_wait_prefix = pfx;
		// status only moves with a new status read, so a running read sees it steady
		if (esc == 8'hDF && modrm == 8'hE0) status_word = 16'($urandom);
		for (int k = 0; k < 1000 && !ok; k++) begin
			@(posedge mclk);
			ok = issue_ready;
		end
		@(negedge mclk);
		issue_valid = 1'b0;
		issue_escape = ~esc;
		issue_modrm = ~modrm;
		issue_wait_prefix = ~pfx;
		unit_busy = (stall > 0);
		if (stall > 0) begin
			repeat (stall) @(negedge mclk);
			unit_busy = 1'b0;
		end
	endtask
endmodule // fpu_issue_model
`default_nettype wire

//--- testbench/fpu_arith_store_decoder_tb.sv
// self-checking bench for the decode and sequencing slice
`timescale 1ns/1ps
`default_nettype none
module fpu_arith_store_decoder_tb;
	logic mclk, rst_n, issue_valid, issue_wait_prefix, unit_busy, ok;
	logic [7:0] issue_escape, issue_modrm;
	logic [15:0] status_word;
	wire issue_ready, op_start, op_uses_element, op_to_element, op_pop, op_push;
	wire op_done, op_illegal, acc_load, seq_busy;
	wire [4:0] op_code;
	wire [2:0] op_mem_format, op_element, op_top, top_ptr;
	wire [7:0] op_clocks;
	wire [15:0] acc_data;
	int failures, tests_run, illegal_seen, since;
	logic [25:0] notes [$];
	logic [25:0] cur;
	logic [2:0] top_m;
	// esc, modrm, {code, format}, {uses, to element, pop, push}, clocks
	logic [39:0] tbl [0:40] = '{
		40'hDCC808C006, 40'hD8C8088006, 40'hDC080A0006, 40'hD808090005, 40'hDEC808E006,
		40'hDA0814000B, 40'hDE0815000A, 40'hD9F320E0A1, 40'hD9F828805B, 40'hD9F530805B,
		40'hD9F2381081, 40'hD9FC400014, 40'hDD20800048, 40'hDD30880041, 40'hD9FD48800E,
		40'hD9FE50008C, 40'hD9FB5810A1, 40'hD9FA60003C, 40'hDDD068C002, 40'hDD106A0002,
		40'hD910690002, 40'hDBD868E002, 40'hDB386B2002, 40'hDD186A2002, 40'hD918692002,
		40'hDF307F203F, 40'hDB1074000D, 40'hDF1075000A, 40'hDF3876200D, 40'hDB1874200D,
		40'hDF1875200A, 40'hD938900003, 40'hD930980016, 40'hDFE0A00002, 40'hDCE818C007,
		40'hD8E0188007, 40'hDC201A0007, 40'hD820190007, 40'hDEE818E007, 40'h9B00A80002,
		40'hD9D0000002};
	fpu_arith_store_decoder #(.CW(8)) uut (.mclk, .rst_n, .issue_valid, .issue_escape,
		.issue_modrm, .issue_wait_prefix, .unit_busy, .status_word, .issue_ready, .op_start,
		.op_code, .op_mem_format, .op_uses_element, .op_to_element, .op_element, .op_top,
		.op_pop, .op_push, .op_clocks, .op_done, .op_illegal, .acc_load, .acc_data, .top_ptr,
		.seq_busy);
	fpu_issue_model drv (.mclk, .issue_ready, .issue_valid, .issue_escape, .issue_modrm,
		.issue_wait_prefix, .unit_busy, .status_word);
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// ****
	// compare, verdict
	// ****
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ****
	// output watcher: oldest note against each start
	// ****
	always @(negedge mclk) begin
		if (rst_n) begin
			since = op_start ? 0 : since + 1;
			if (op_illegal) illegal_seen++;
			if (op_start && notes.size() == 0) begin
				failures++;
				$display("mismatch op_start expected 0 seen 1");
			end else if (op_start) begin
				cur = notes.pop_front();
				chk("op_code", 16'(cur[25:21]), 16'(op_code));
				if (cur[25:21] < 5'h10 || cur[25:21] > 5'h13)
					chk("op_mem_format", 16'(cur[20:18]), 16'(op_mem_format));
				chk("op_uses_element", 16'(cur[17]), 16'(op_uses_element));
				if (cur[17]) chk("op_to_element", 16'(cur[16]), 16'(op_to_element));
				if (cur[17]) chk("op_element", 16'(cur[13:11]), 16'(op_element));
				chk("op_pop", 16'(cur[15]), 16'(op_pop));
				chk("op_push", 16'(cur[14]), 16'(op_push));
				chk("op_top", 16'(cur[10:8]), 16'(op_top));
				chk("op_clocks", 16'(cur[7:0]), 16'(op_clocks));
			end
			if (op_done) chk("done delay", 16'(cur[7:0]) + 16'h0003, 16'(since));
			if (acc_load) chk("acc_data", status_word, acc_data);
		end
	end
	// ****
	// stimulus
	// ****
	task automatic run(input int i, input logic pfx);
		logic [39:0] t;
		logic [7:0] m;
		logic [2:0] el;
		t = tbl[i];
		m = t[31:24];
		if (m[7:6] == 2'h3 && t[15] && t[39:32] != 8'hD9) m[2:0] = 3'($urandom);
		if (m[7:6] == 2'h0) m = {2'($urandom % 3), m[5:3], 3'($urandom)};
		el = (t[39:32] == 8'hD9) ? top_m + 3'h1 : top_m + m[2:0];
		notes.push_back({t[23:12], el, top_m, t[7:0] + (pfx ? 8'h02 : 8'h00)});
		top_m = top_m + {2'h0, t[13]} - {2'h0, t[12]};
		drv.issue(t[39:32], m, pfx, $urandom % 4, ok);
		if (!ok) chk("issue taken", 16'h0001, 16'h0000);
	endtask
	task automatic idle_check;
		int k;
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while ((!issue_ready || notes.size() != 0) && k < 400);
		// the pointer output trails the done pulse by two cycles
		repeat (2) @(negedge mclk);
		chk("issue_ready", 16'h0001, 16'(issue_ready));
		chk("seq_busy", 16'h0000, 16'(seq_busy));
		chk("top_ptr", 16'(top_m), 16'(top_ptr));
	endtask
	initial begin
		rst_n = 1'b0;
		failures = 0;
		tests_run = 0;
		illegal_seen = 0;
		since = 0;
		top_m = 3'h0;
		void'($urandom(76));
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		rst_n = 1'b1;
		idle_check();
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 41; i++) run(i, p == 1 ? 1'($urandom) : 1'b0);
		drv.issue(8'hD9, 8'hE4, 1'b0, 0, ok);
		idle_check();
		chk("illegal pulses", 16'h0001, 16'(illegal_seen));
		// reset while a long op runs must leave no trace of it
		run(15, 1'b0);
		repeat (10) @(negedge mclk);
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		notes.delete();
		top_m = 3'h0;
		idle_check();
		run(4, 1'b0);
		idle_check();
		end_of_test();
	end
	// both passes need some 3100 cycles; allow well over double
	initial begin
		#(40 * 10000);
		failures++;
		end_of_test();
	end
endmodule // fpu_arith_store_decoder_tb
`default_nettype wire
